// [rtc_dev_end.sv]
// Clock-side access port: lock and key, indirect address and data registers
`timescale 1ns/10ps

// Operation
// - Unlock only after first then second key
// - No timing limit between the two keys
// - Bad key, or address write or data access while locked, disables until reset
// - Unlocked port allows unlimited indirect accesses
// - Any key write while unlocked relocks
// - Key register read returns status, disturbs nothing
// - Address register selects the internal target
// - Data register write starts indirect write
// - Busy bit write starts indirect read
// - Host polls busy unless spacing is kept
// - Transfer takes seven cycles, six when short
// - Short strobe on at reset, bit four
// - Autoread: data read starts next read
// - Host sets busy once per autoread series
// - Capture and alarm bytes autoincrement address
// - Reset keeps select and data contents; address flags reset
// - Control register sits at address five
// - Host waits three slots before reading data
// - Status codes locked, first, open, disabled
// - Key writes ignored while disabled
// - Four-bit select in low address bits
// - Internal registers sit in another timebase
module rtc_dev_end #(
	parameter int unsigned LONG_CYC  = rtc_pkg::ACC_LONG_CYC,
	parameter int unsigned SHORT_CYC = rtc_pkg::ACC_SHORT_CYC
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Core side
	rtc_if.dev              bus,
	// Internal register side
	output logic [3:0]      int_addr,
	output logic [7:0]      int_wdata,
	output logic            int_wr,
	output logic            int_rd,
	input  wire logic [7:0] int_rdata,
	output logic            int_ctrl_sel
);
	// ****************************************
	// Lock state
	// ****************************************
	typedef enum logic [1:0] {
		LK_LOCKED   = 2'b00,
		LK_FIRST    = 2'b01,
		LK_OPEN     = 2'b11,
		LK_DISABLED = 2'b10
	} lock_t;

	function automatic logic [7:0] lock_code(input lock_t s);
		unique case (s)
			LK_LOCKED:   lock_code = rtc_pkg::CODE_LOCKED;
			LK_FIRST:    lock_code = rtc_pkg::CODE_FIRST;
			LK_OPEN:     lock_code = rtc_pkg::CODE_OPEN;
			LK_DISABLED: lock_code = rtc_pkg::CODE_DISABLED;
		endcase
	endfunction

	function automatic logic is_multi(input logic [3:0] a);
		is_multi = (a >= rtc_pkg::CAPT_LO && a <= rtc_pkg::CAPT_HI) ||
			(a >= rtc_pkg::ALARM_LO && a <= rtc_pkg::ALARM_HI);
	endfunction

	lock_t      lock_q;
	lock_t      lock_d;
	logic       busy_q;
	logic       write_q;
	logic [2:0] cnt_q;
	logic       auto_read_enable_q;
	logic       short_q;
	logic [3:0] sel_q;
	logic [7:0] data_q;
	logic [7:0] rdata_q;

	logic wr_key;
	logic wr_adr;
	logic wr_dat;
	logic rd_dat;
	logic rd_any;
	logic open;
	logic violation;
	logic start_rd;
	logic start_wr;
	logic done;
	logic adr_take;

	// ****************************************
	// Decode
	// ****************************************
	assign wr_key = bus.sfr_wr && bus.sfr_addr == rtc_pkg::ADR_KEY;
	assign wr_adr = bus.sfr_wr && bus.sfr_addr == rtc_pkg::ADR_ADDR;
	assign wr_dat = bus.sfr_wr && bus.sfr_addr == rtc_pkg::ADR_DATA;
	assign rd_dat = bus.sfr_rd && bus.sfr_addr == rtc_pkg::ADR_DATA;
	assign rd_any = bus.sfr_rd;
	assign open   = lock_q == LK_OPEN;
	// Only indirect traffic counts; reading the key register is always harmless
	assign violation = !open && (wr_adr || wr_dat || rd_dat);

	// Writes arriving mid-transfer are dropped so the pending byte is not torn
	assign adr_take = open && wr_adr && !busy_q;
	assign start_rd = open && !busy_q &&
		((wr_adr && bus.sfr_wdata[rtc_pkg::BUSY_BIT]) || (rd_dat && auto_read_enable_q));
	assign start_wr = open && !busy_q && wr_dat;
	assign done     = busy_q && cnt_q == 3'd0;

	// ****************************************
	// Lock and key
	// ****************************************
	always_comb begin
		lock_d = lock_q;
		if (violation && lock_q != LK_DISABLED) begin
			lock_d = LK_DISABLED;
		end else if (wr_key) begin
			unique case (lock_q)
				LK_LOCKED: begin
					lock_d = bus.sfr_wdata == rtc_pkg::KEY_FIRST ? LK_FIRST : LK_DISABLED;
				end
				LK_FIRST: begin
					// No timeout while waiting here
					lock_d = bus.sfr_wdata == rtc_pkg::KEY_SECOND ? LK_OPEN : LK_DISABLED;
				end
				LK_OPEN:     lock_d = LK_LOCKED;
				LK_DISABLED: lock_d = LK_DISABLED;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lock_q <= LK_LOCKED;
		end else begin
			lock_q <= lock_d;
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	// The internal registers live on the slow timebase; the fixed strobe
	// length stands in for the crossing so the core sees a fixed latency.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_q  <= 1'b0;
			write_q <= 1'b0;
			cnt_q   <= 3'd0;
		end else if (start_rd || start_wr) begin
			busy_q  <= 1'b1;
			write_q <= start_wr;
			cnt_q   <= short_q ? 3'(SHORT_CYC - 1) : 3'(LONG_CYC - 1);
		end else if (done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 3'd1;
		end
	end

	assign int_wr = done && write_q;
	assign int_rd = done && !write_q;

	// ****************************************
	// Address register
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			short_q  <= rtc_pkg::SHORT_RST;
			auto_read_enable_q <= rtc_pkg::AUTO_READ_ENABLE_RST;
		end else if (adr_take) begin
			short_q  <= bus.sfr_wdata[rtc_pkg::SHORT_BIT];
			auto_read_enable_q <= bus.sfr_wdata[rtc_pkg::AUTO_READ_ENABLE_BIT];
		end
	end

	// Select and data survive reset on purpose; contents are unknown at power-up
	always_ff @(posedge sys_clk) begin
		if (adr_take) begin
			sel_q <= bus.sfr_wdata[rtc_pkg::SEL_MSB:0];
		end else if (done && is_multi(sel_q)) begin
			sel_q <= sel_q + 4'd1;
		end
	end

	// ****************************************
	// Data register
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (start_wr) begin
			data_q <= bus.sfr_wdata;
		end else if (int_rd) begin
			data_q <= int_rdata;
		end
	end

	assign int_addr     = sel_q;
	assign int_wdata    = data_q;
	assign int_ctrl_sel = sel_q == rtc_pkg::CTRL_SEL;

	// ****************************************
	// Read-back
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (!rd_any) begin
			rdata_q <= 8'h00;
		end else begin
			unique case (bus.sfr_addr)
				rtc_pkg::ADR_KEY: begin
					rdata_q <= lock_code(lock_q);
				end
				rtc_pkg::ADR_ADDR: begin
					rdata_q <= open ? {busy_q, auto_read_enable_q, 1'b0, short_q, sel_q} : 8'h00;
				end
				rtc_pkg::ADR_DATA: begin
					rdata_q <= open ? data_q : 8'h00;
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end
	end

	assign bus.sfr_rdata = rdata_q;
endmodule

// [rtc_pkg.sv]
// Shared constants for the locked indirect access port of the real-time clock
package rtc_pkg;
	// ****************************************
	// Port register addresses on the byte bus
	// ****************************************
	localparam logic [7:0] ADR_KEY = 8'hAE;
	localparam logic [7:0] ADR_ADDR = 8'hAC;
	localparam logic [7:0] ADR_DATA = 8'hAD;

	// ****************************************
	// Key values and status codes
	// ****************************************
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;
	localparam logic [7:0] CODE_LOCKED = 8'h00;
	localparam logic [7:0] CODE_FIRST = 8'h01;
	localparam logic [7:0] CODE_OPEN = 8'h02;
	localparam logic [7:0] CODE_DISABLED = 8'h03;

	// ****************************************
	// Address register fields and reset values
	// ****************************************
	localparam int BUSY_BIT = 7;
	localparam int AUTO_READ_ENABLE_BIT = 6;
	localparam int SHORT_BIT = 4;
	localparam int SEL_MSB = 3;
	localparam logic SHORT_RST = 1'b1;
	localparam logic AUTO_READ_ENABLE_RST = 1'b0;

	// ****************************************
	// Internal register map
	// ****************************************
	localparam logic [3:0] CTRL_SEL = 4'h5;
	localparam logic [3:0] CAPT_LO = 4'h0;
	localparam logic [3:0] CAPT_HI = 4'h3;
	localparam logic [3:0] ALARM_LO = 4'h8;
	localparam logic [3:0] ALARM_HI = 4'hB;

	// ****************************************
	// Transfer timing in system clock cycles
	// ****************************************
	localparam int ACC_LONG_CYC = 7;
	localparam int ACC_SHORT_CYC = 6;

	// ****************************************
	// Controller software registers and orders
	// ****************************************
	localparam logic [2:0] HREG_CMD = 3'h0;
	localparam logic [2:0] HREG_SEL = 3'h1;
	localparam logic [2:0] HREG_WDATA = 3'h2;
	localparam logic [2:0] HREG_STATUS = 3'h3;
	localparam logic [2:0] HREG_RDATA = 3'h4;
	localparam logic [1:0] OP_UNLOCK = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_RELOCK = 2'h3;
endpackage

// [rtc_if.sv]
// Byte-wide special function register bus between core and clock port
`timescale 1ns/10ps
interface rtc_if;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;

	modport dev (
		input  sfr_addr,
		input  sfr_wdata,
		input  sfr_wr,
		input  sfr_rd,
		output sfr_rdata
	);
	modport host (
		output sfr_addr,
		output sfr_wdata,
		output sfr_wr,
		output sfr_rd,
		input  sfr_rdata
	);
endinterface

// [rtc_host_end.sv]
// Core-side controller: runs unlock, indirect write, indirect read and relock
`timescale 1ns/10ps
module rtc_host_end (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Software register port
	input  wire logic [2:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [7:0]      sw_rdata,
	// Clock port side
	rtc_if.host             bus
);
	// ****************************************
	// Sequencer
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_KEY2   = 4'b0001,
		ST_POLL   = 4'b0011,
		ST_CHK    = 4'b0010,
		ST_REPOLL = 4'b0110,
		ST_WDAT   = 4'b0111,
		ST_DWAIT  = 4'b0101,
		ST_DCAP   = 4'b0100,
		ST_FIN    = 4'b1100
	} hstate_t;

	hstate_t    state_q;
	logic [1:0] op_q;
	logic       phase_q;
	logic [7:0] sel_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic [7:0] addr_q;
	logic [7:0] out_q;
	logic       wr_q;
	logic       rd_q;
	logic [7:0] sw_rdata_q;
	logic       go;

	assign go = sw_wr && sw_addr == rtc_pkg::HREG_CMD && state_q == ST_IDLE;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			op_q    <= rtc_pkg::OP_UNLOCK;
			phase_q <= 1'b0;
			rdata_q <= 8'h00;
			addr_q  <= 8'h00;
			out_q   <= 8'h00;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: if (go) begin
					op_q    <= sw_wdata[1:0];
					phase_q <= 1'b0;
					addr_q  <= sw_wdata[1:0] inside {rtc_pkg::OP_WRITE, rtc_pkg::OP_READ} ?
						rtc_pkg::ADR_ADDR : rtc_pkg::ADR_KEY;
					out_q   <= sw_wdata[1:0] == rtc_pkg::OP_UNLOCK ? rtc_pkg::KEY_FIRST : 8'h00;
					wr_q    <= !(sw_wdata[1:0] inside {rtc_pkg::OP_WRITE, rtc_pkg::OP_READ});
					rd_q    <= sw_wdata[1:0] inside {rtc_pkg::OP_WRITE, rtc_pkg::OP_READ};
					state_q <= sw_wdata[1:0] == rtc_pkg::OP_UNLOCK ? ST_KEY2 :
						sw_wdata[1:0] == rtc_pkg::OP_RELOCK ? ST_FIN : ST_POLL;
				end
				ST_KEY2: begin
					out_q   <= rtc_pkg::KEY_SECOND;
					wr_q    <= 1'b1;
					state_q <= ST_FIN;
				end
				ST_POLL: state_q <= ST_CHK;
				ST_CHK: begin
					if (bus.sfr_rdata[rtc_pkg::BUSY_BIT]) begin
						rd_q    <= 1'b1;
						state_q <= ST_POLL;
					end else if (phase_q) begin
						addr_q  <= rtc_pkg::ADR_DATA;
						rd_q    <= 1'b1;
						state_q <= ST_DWAIT;
					end else begin
						// Read sets busy once; autoread is left to software series
						out_q   <= {op_q == rtc_pkg::OP_READ, sel_q[6:0]};
						wr_q    <= 1'b1;
						phase_q <= op_q == rtc_pkg::OP_READ;
						state_q <= op_q == rtc_pkg::OP_READ ? ST_REPOLL : ST_WDAT;
					end
				end
				ST_REPOLL: begin
					// Polling instead of fixed spacing keeps long strobes safe
					rd_q    <= 1'b1;
					state_q <= ST_POLL;
				end
				ST_WDAT: begin
					addr_q  <= rtc_pkg::ADR_DATA;
					out_q   <= wdata_q;
					wr_q    <= 1'b1;
					state_q <= ST_FIN;
				end
				ST_DWAIT: state_q <= ST_DCAP;
				ST_DCAP: begin
					rdata_q <= bus.sfr_rdata;
					state_q <= ST_IDLE;
				end
				ST_FIN: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign bus.sfr_addr  = addr_q;
	assign bus.sfr_wdata = out_q;
	assign bus.sfr_wr    = wr_q;
	assign bus.sfr_rd    = rd_q;

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sel_q   <= 8'h10;
			wdata_q <= 8'h00;
		end else if (sw_wr && sw_addr == rtc_pkg::HREG_SEL) begin
			sel_q <= sw_wdata;
		end else if (sw_wr && sw_addr == rtc_pkg::HREG_WDATA) begin
			wdata_q <= sw_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sw_rdata_q <= 8'h00;
		end else if (!sw_rd) begin
			sw_rdata_q <= 8'h00;
		end else begin
			unique case (sw_addr)
				rtc_pkg::HREG_SEL:    sw_rdata_q <= sel_q;
				rtc_pkg::HREG_WDATA:  sw_rdata_q <= wdata_q;
				rtc_pkg::HREG_STATUS: sw_rdata_q <= {7'h00, state_q != ST_IDLE};
				rtc_pkg::HREG_RDATA:  sw_rdata_q <= rdata_q;
				default:              sw_rdata_q <= 8'h00;
			endcase
		end
	end

	assign sw_rdata = sw_rdata_q;
endmodule

// [rtc_bus_sva.sv]
// Checker for the byte bus between the core controller and the clock port
`timescale 1ns/10ps
module rtc_bus_sva (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       resetn,
	// Register bus
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata
);
	// *****
	// Shadow of lock state, flags and busy span
	// *****
	logic [1:0] lock_q;
	logic       sh_q;
	logic       ar_q;
	logic [2:0] cnt_q;
	wire        open = lock_q == 2'h2;
	wire        busy = cnt_q != 3'h0;
	wire        ka   = sfr_addr == rtc_pkg::ADR_KEY;
	wire        aa   = sfr_addr == rtc_pkg::ADR_ADDR;
	wire        da   = sfr_addr == rtc_pkg::ADR_DATA;
	wire        go   = open && !busy && (sfr_wr && (da || aa && sfr_wdata[7]) || sfr_rd && da && ar_q);

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			lock_q <= 2'h0;
		else if (sfr_wr && ka && lock_q != 2'h3)
			lock_q <= open ? 2'h0 : (sfr_wdata == (lock_q[0] ? rtc_pkg::KEY_SECOND : rtc_pkg::KEY_FIRST)) ?
				lock_q + 2'h1 : 2'h3;
		else if (!open && (sfr_wr && (aa || da) || sfr_rd && da))
			lock_q <= 2'h3;
	end

	// Writes that land while busy are dropped, so flags follow only idle writes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sh_q <= 1'b1;
			ar_q <= 1'b0;
		end else if (open && !busy && sfr_wr && aa) begin
			sh_q <= sfr_wdata[4];
			ar_q <= sfr_wdata[6];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			cnt_q <= 3'h0;
		else if (go)
			// Length follows the short flag held before this write, as the port does
			cnt_q <= sh_q ? 3'(rtc_pkg::ACC_SHORT_CYC) : 3'(rtc_pkg::ACC_LONG_CYC);
		else if (busy)
			cnt_q <= cnt_q - 3'h1;
	end

	a_rdata_idle_zero: assert property (!sfr_rd |=> sfr_rdata == 8'h00) else $error("read data not idle");
	a_busy_flag_span: assert property (sfr_rd && aa && open |=> sfr_rdata[7] == $past(busy))
		else $error("busy flag wrong");
	a_addr_mode_flags: assert property (sfr_rd && aa && open |=> sfr_rdata[6:4] == {$past(ar_q), 1'b0, $past(sh_q)})
		else $error("address flags wrong");
	a_data_read_idle: assert property (sfr_rd && da && open |-> !busy) else $error("data read while busy");
	a_host_waits_busy: assert property (sfr_wr && (aa || da) |-> !busy) else $error("write while busy");
	a_host_never_disabled: assert property (lock_q != 2'h3) else $error("port disabled");
	a_first_key_value: assert property (sfr_wr && ka && lock_q == 2'h0 |-> sfr_wdata == rtc_pkg::KEY_FIRST)
		else $error("first key wrong");
	a_second_key_value: assert property (sfr_wr && ka && lock_q == 2'h1 |-> sfr_wdata == rtc_pkg::KEY_SECOND)
		else $error("second key wrong");

	c_unlock: cover property (lock_q == 2'h1 ##1 open);
	c_read: cover property (go && aa);
	c_write: cover property (go && da);
	c_relock: cover property (open && sfr_wr && ka);
endmodule

// [rtc_locked_indirect_access_tb_top.sv]
// Bench for both ends of the locked indirect access port
`timescale 1ns/10ps
module rtc_locked_indirect_access_tb_top;
	// *****
	// Signals
	// *****
	logic       sys_clk;
	logic       resetn;
	logic [2:0] sw_addr;
	logic [7:0] sw_wdata;
	logic       sw_wr;
	logic       sw_rd;
	logic [7:0] sw_rdata;
	logic [3:0] ia, ib, at;
	logic [7:0] iwa, iwb, ira, irb;
	logic       wra, rda, wrb, rdb, csb;
	logic [7:0] mem [16];
	int         n_errors;
	int         n_compared;
	int         n;
	rtc_if bus ();
	rtc_if bus_b ();

	// Second device end is driven by the bench so that faults can be injected
	rtc_dev_end u_rtc_dev_end (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .int_addr(ia), .int_wdata(iwa),
		.int_wr(wra), .int_rd(rda), .int_rdata(ira), .int_ctrl_sel());
	rtc_dev_end u_rtc_dev_end_b (.sys_clk(sys_clk), .resetn(resetn), .bus(bus_b), .int_addr(ib),
		.int_wdata(iwb), .int_wr(wrb), .int_rd(rdb), .int_rdata(irb), .int_ctrl_sel(csb));
	rtc_host_end u_rtc_host_end (.sys_clk(sys_clk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus));
	rtc_bus_sva u_rtc_bus_sva (.sys_clk(sys_clk), .resetn(resetn), .sfr_addr(bus.sfr_addr),
		.sfr_wdata(bus.sfr_wdata), .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_rdata(bus.sfr_rdata));

	always @(posedge sys_clk) if (wra) mem[ia] <= iwa;
	assign ira = mem[ia];
	assign irb = {4'hC, ib};

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// *****
	// Tasks
	// *****
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkn(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic rst(input int k);
		resetn <= 1'b0;
		repeat (k) @(posedge sys_clk);
		#1;
		resetn <= 1'b1;
	endtask

	// One bus cycle; the strobes stay as driven until the next call sets them again
	task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		bus_b.sfr_wr <= w;
		bus_b.sfr_rd <= r;
		bus_b.sfr_addr <= a;
		bus_b.sfr_wdata <= d;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		cyc(1'b1, 1'b0, a, d);
	endtask

	task automatic rd_b(input logic [7:0] a, input logic [7:0] exp, input string what);
		cyc(1'b0, 1'b1, a, 8'h00);
		chk8(what, exp, bus_b.sfr_rdata);
	endtask

	// Counts cycles from the starting edge to the internal strobe
	task automatic wt(input logic is_rd, output int k);
		k = 1;
		while ((is_rd ? rdb : wrb) !== 1'b1 && k < 20) begin
			cyc(1'b0, 1'b0, 8'h00, 8'h00);
			k++;
		end
		at = ib;
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic scyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		sw_wr <= w;
		sw_rd <= r;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic scmd(input logic [1:0] op);
		scyc(1'b1, 1'b0, rtc_pkg::HREG_CMD, {6'h00, op});
		scyc(1'b0, 1'b0, 3'h0, 8'h00);
		n = 0;
		do begin
			scyc(1'b0, 1'b1, rtc_pkg::HREG_STATUS, 8'h00);
			n++;
		end while (sw_rdata[0] !== 1'b0 && n < 200);
		chkn("host done", 1, n < 200);
	endtask

	task automatic complete_run;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// *****
	// Tests
	// *****
	initial begin
		{resetn, sw_addr, sw_wdata, sw_wr, sw_rd, n_errors, n_compared} = '0;
		{bus_b.sfr_addr, bus_b.sfr_wdata, bus_b.sfr_wr, bus_b.sfr_rd} = '0;
		rst(16);
		scyc(1'b1, 1'b0, rtc_pkg::HREG_SEL, 8'h15);
		scyc(1'b1, 1'b0, rtc_pkg::HREG_WDATA, 8'h5A);
		scmd(rtc_pkg::OP_UNLOCK);
		scmd(rtc_pkg::OP_WRITE);
		scmd(rtc_pkg::OP_READ);
		scyc(1'b0, 1'b1, rtc_pkg::HREG_RDATA, 8'h00);
		chk8("host read back", 8'h5A, sw_rdata);
		chk8("stored byte", 8'h5A, mem[5]);
		scmd(rtc_pkg::OP_RELOCK);
		scyc(1'b0, 1'b0, 3'h0, 8'h00);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_LOCKED, "status after reset");
		rd_b(rtc_pkg::ADR_ADDR, 8'h00, "locked address read");
		wr_b(rtc_pkg::ADR_KEY, rtc_pkg::KEY_FIRST);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_FIRST, "first key status");
		repeat (9) cyc(1'b0, 1'b0, 8'h00, 8'h00);
		wr_b(rtc_pkg::ADR_KEY, rtc_pkg::KEY_SECOND);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_OPEN, "open status");
		wr_b(rtc_pkg::ADR_ADDR, 8'h05);
		chk8("control select", 8'h01, {7'h00, csb});
		wr_b(rtc_pkg::ADR_DATA, 8'h3C);
		wt(1'b0, n);
		chkn("long write cycles", 7, n);
		chk8("written byte", 8'h3C, iwb);
		wr_b(rtc_pkg::ADR_ADDR, 8'h95);
		wt(1'b1, n);
		// Short flag set by this same write only takes effect on the next transfer
		chkn("read cycles short set in same write", 7, n);
		rd_b(rtc_pkg::ADR_DATA, 8'hC5, "read copy");
		rd_b(rtc_pkg::ADR_ADDR, 8'h15, "address flags");
		wr_b(rtc_pkg::ADR_ADDR, 8'hD0);
		for (int i = 0; i < 4; i++) begin
			wt(1'b1, n);
			chkn("autoread cycles", 6, n);
			rd_b(rtc_pkg::ADR_DATA, {4'hC, i[3:0]}, "autoread byte");
		end
		wt(1'b1, n);
		rd_b(rtc_pkg::ADR_ADDR, 8'h54, "incremented address");
		wr_b(rtc_pkg::ADR_ADDR, 8'h08);
		for (int i = 0; i < 2; i++) begin
			wr_b(rtc_pkg::ADR_DATA, 8'h20 + i[7:0]);
			wt(1'b0, n);
			chk8("write target", {4'h0, 4'h8 + i[3:0]}, {4'h0, at});
		end
		wr_b(rtc_pkg::ADR_KEY, 8'h00);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_LOCKED, "relocked");
		wr_b(rtc_pkg::ADR_KEY, rtc_pkg::KEY_SECOND);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_DISABLED, "bad key");
		wr_b(rtc_pkg::ADR_KEY, rtc_pkg::KEY_FIRST);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_DISABLED, "disabled stays");
		rst(3);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_LOCKED, "status after second reset");
		wr_b(rtc_pkg::ADR_KEY, rtc_pkg::KEY_FIRST);
		wr_b(rtc_pkg::ADR_KEY, rtc_pkg::KEY_SECOND);
		rd_b(rtc_pkg::ADR_ADDR, 8'h1A, "kept address");
		rd_b(rtc_pkg::ADR_DATA, 8'h21, "kept data");
		rst(3);
		wr_b(rtc_pkg::ADR_DATA, 8'h00);
		rd_b(rtc_pkg::ADR_KEY, rtc_pkg::CODE_DISABLED, "locked access");
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
		complete_run;
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		complete_run;
	end
endmodule
